// *** core/dspm_pkg.sv ***
// dspm_pkg: constants and types shared by the ds3 performance monitor
// assumes one 20 MHz clock domain for the framer, decoder and management

package dspm_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 50;
    localparam int ONE_SECOND_NS  = 1000000000;
    localparam int CYC_PER_SEC    = ONE_SECOND_NS / CLK_PERIOD_NS;
    localparam int INTERVAL_MIN   = 15;
    localparam int SEC_PER_MIN    = 60;
    localparam int INTERVAL_SEC   = INTERVAL_MIN * SEC_PER_MIN;
    localparam int SEC_W          = 10;
    localparam int TIMER_W        = 32;
    // ------------------------------------------------------------
    // storage shape
    // ------------------------------------------------------------
    localparam int HIST_DEPTH     = 96;
    localparam int IDX_W          = 7;
    localparam int TOD_W          = 11;
    localparam int CW             = 32;
    localparam int ACW            = 16;
    localparam int INC_W          = 2;
    localparam int SCNT_W         = 6;
    localparam logic [SCNT_W-1:0] SEVERE_CV = 6'h2C;
    // ------------------------------------------------------------
    // parameter slots in a record
    // ------------------------------------------------------------
    localparam int NPAR   = 12;
    localparam int P_UNAV = 0;
    localparam int P_SFRM = 1;
    localparam int P_LNCV = 2;
    localparam int P_LNES = 3;
    localparam int P_PBES = 4;
    localparam int P_PBSS = 5;
    localparam int P_PBCV = 6;
    localparam int P_CBCV = 7;
    localparam int P_CBES = 8;
    localparam int P_CBSS = 9;
    localparam int P_FERR = 10;
    localparam int P_MERR = 11;
    // ------------------------------------------------------------
    // alarm slots
    // ------------------------------------------------------------
    localparam int NALM   = 3;
    localparam int AL_YEL = 0;
    localparam int AL_BLU = 1;
    localparam int AL_RED = 2;
    localparam int NPORT  = 4;

    typedef logic [CW-1:0] dspm_cnt_t;
    typedef dspm_cnt_t [NPAR-1:0] dspm_rec_t;
endpackage

// *** core/dspm_ctl_if.sv ***
// dspm_ctl_if: clear and interval restart for the current-interval counters
// assumes the driver and all takers share one clock
`timescale 1ns/1ns

interface dspm_ctl_if;
    logic clear;
    logic restart;
    modport drive (output clear, output restart);
    modport take  (input clear, input restart);
endinterface

// *** core/dspm_counter.sv ***
// dspm_counter: one current-interval counter with clear and restart
// assumes clear and restart come from the same clock domain
`timescale 1ns/1ns

module dspm_counter
    import dspm_pkg::*;
#(
    parameter int W  = 32,
    parameter int IW = 2
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          reset,
    // control
    dspm_ctl_if.take           ctl,
    input  wire logic [IW-1:0] inc,
    // count
    output logic      [W-1:0]  count,
    output logic      [W-1:0]  count_next
);
    typedef struct packed {
        logic [W-1:0] count;
    } dspm_cnt_st_t;

    dspm_cnt_st_t st_reg;
    dspm_cnt_st_t st_next;

    always_comb begin
        st_next    = st_reg;
        count_next = st_reg.count + W'(inc);
        if (ctl.clear) begin
            st_next.count = W'(inc);
        end else if (ctl.restart) begin
            st_next.count = '0;
        end else begin
            st_next.count = count_next;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign count = st_reg.count;

    a_count_step: assert property (@(posedge clock) disable iff (reset)
        !ctl.clear && !ctl.restart |=> count == $past(count) + W'($past(inc)))
        else $error("counter did not add its increment");
    a_clear_keeps: assert property (@(posedge clock) disable iff (reset)
        ctl.clear |=> count == W'($past(inc)))
        else $error("clear did not restart count at new events");
endmodule // dspm_counter

// *** core/dspm_alarm_count.sv ***
// dspm_alarm_count: cumulative occurrence count of one alarm level
// assumes the alarm level is already synchronous to clock
`timescale 1ns/1ns

module dspm_alarm_count
    import dspm_pkg::*;
#(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         reset,
    // alarm
    input  wire logic         level,
    input  wire logic         enable,
    input  wire logic         clear,
    // count
    output logic      [W-1:0] count
);
    typedef struct packed {
        logic         prev;
        logic [W-1:0] count;
    } dspm_alm_st_t;

    dspm_alm_st_t st_reg;
    dspm_alm_st_t st_next;
    logic         rise;

    always_comb begin
        st_next      = st_reg;
        rise         = level & ~st_reg.prev & enable;
        st_next.prev = level;
        if (clear) begin
            st_next.count = W'(rise);
        end else begin
            st_next.count = st_reg.count + W'(rise);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign count = st_reg.count;

    sequence s_held;
        level ##1 level;
    endsequence

    a_alarm_held: assert property (@(posedge clock) disable iff (reset)
        s_held ##0 !clear |=> count == $past(count))
        else $error("held alarm counted again");
    a_alarm_rise: assert property (@(posedge clock) disable iff (reset)
        rise && !clear |=> count == $past(count) + W'(1))
        else $error("alarm onset not counted");
    a_alarm_clear: assert property (@(posedge clock) disable iff (reset)
        clear && !rise |=> count == '0)
        else $error("alarm clear did not zero count");
endmodule // dspm_alarm_count

// *** core/dspm_perf_monitor.sv ***
// dspm_perf_monitor: ds3 performance counters, 24-hour history, alarm counts
// assumes framer events, defects, alarms and management are on clock
//
// Behaviour
// - count yellow, blue and red alarm occurrences of the ds3 port
// - cumulative alarm counts grow until the alarm clear command
// - an alarm counts once per inactive-to-active transition
// - keep separate alarm counts per port when the four-port card exists
// - keep 96 fifteen-minute records plus the current interval
// - each history record carries its starting time of day
// - unavailable seconds count seconds with link down, test or signaling down
// - severe framing seconds count seconds with out-of-frame or ais
// - line code violations add every bipolar violation and excess zeros
// - line errored seconds count seconds with code violation or los
// - p-bit errored seconds: violation, out-of-frame or ais; not when unavailable
// - p-bit severe seconds: 44 violations, out-of-frame or ais; not when unavailable
// - p-bit code violations add one per p-bit violation
// - c-bit code violations count parity errors in c-bit mode only
// - c-bit errored seconds: violation, out-of-frame or ais; not when unavailable
// - c-bit severe seconds: 44 violations, out-of-frame or ais; not when unavailable
// - f-bit error count adds one per f-bit framing error
// - counts cover only their period since the last clear
// - m-bit error count adds one per m-bit framing error
// - statistics clear zeroes history and totals and restarts current at that cycle's events
`timescale 1ns/1ns

module dspm_perf_monitor
    import dspm_pkg::*;
#(
    parameter int SEC_CYCLES = CYC_PER_SEC
) (
    // clock and reset
    input  wire logic                                clock,
    input  wire logic                                reset,
    // line and framer events, one-cycle pulses
    input  wire logic                                bipolar_violation,
    input  wire logic                                excess_zeros_event,
    input  wire logic                                pbit_violation,
    input  wire logic                                cbit_parity_error,
    input  wire logic                                fbit_error,
    input  wire logic                                mbit_error,
    // defect levels
    input  wire logic                                out_of_frame_defect,
    input  wire logic                                ais_detected,
    input  wire logic                                loss_of_signal,
    input  wire logic                                link_down,
    input  wire logic                                link_in_test,
    input  wire logic                                signaling_down,
    input  wire logic                                cbit_parity_mode,
    // alarm levels
    input  wire logic [NALM-1:0]                     ds3_alarm,
    input  wire logic                                card_present,
    input  wire logic [NPORT-1:0][NALM-1:0]          port_alarm,
    // management
    input  wire logic                                clear_stats,
    input  wire logic                                clear_alarms,
    input  wire logic [TOD_W-1:0]                    time_of_day,
    input  wire logic [IDX_W-1:0]                    hist_sel,
    // counters
    output dspm_rec_t                                current_counts,
    output logic      [TOD_W-1:0]                    current_start_time,
    output dspm_rec_t                                total_counts,
    output dspm_rec_t                                hist_counts,
    output logic      [TOD_W-1:0]                    hist_start_time,
    output logic      [NALM-1:0][ACW-1:0]            ds3_alarm_counts,
    output logic      [NPORT-1:0][NALM-1:0][ACW-1:0] port_alarm_counts
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [TIMER_W-1:0]                   sec_timer;
        logic [SEC_W-1:0]                     iv_sec;
        logic                                 any_unav;
        logic                                 any_oa;
        logic                                 any_line;
        logic                                 any_los;
        logic [SCNT_W-1:0]                    pviol_sec;
        logic [SCNT_W-1:0]                    cviol_sec;
        logic [IDX_W-1:0]                     wr_ptr;
        logic [TOD_W-1:0]                     cur_start;
        dspm_rec_t [HIST_DEPTH-1:0]           hist;
        logic [HIST_DEPTH-1:0][TOD_W-1:0]     hist_time;
        dspm_rec_t                            total;
        dspm_rec_t                            rd_hist;
        logic [TOD_W-1:0]                     rd_time;
    } dspm_st_t;

    dspm_st_t                    st_reg;
    dspm_st_t                    st_next;
    dspm_rec_t                   cur_next;
    logic [NPAR-1:0][INC_W-1:0]  inc;
    logic                        sec_tick;
    logic                        iv_end;
    logic                        unav_now;
    logic                        oa_now;
    logic                        cbit_ev;
    logic                        f_unav;
    logic                        f_oa;
    logic                        f_line;
    logic                        f_los;
    logic [SCNT_W-1:0]           pviol_c;
    logic [SCNT_W-1:0]           cviol_c;
    logic [IDX_W:0]              rd_idx;

    dspm_ctl_if stats_ctl ();

    assign stats_ctl.clear   = clear_stats;
    assign stats_ctl.restart = iv_end;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next  = st_reg;
        unav_now = link_down | link_in_test | signaling_down;
        oa_now   = out_of_frame_defect | ais_detected;
        cbit_ev  = cbit_parity_error & cbit_parity_mode;
        // clear restarts the second, so no tick lands on a clear
        sec_tick = (st_reg.sec_timer == TIMER_W'(SEC_CYCLES - 1)) & ~clear_stats;
        iv_end   = sec_tick & (st_reg.iv_sec == SEC_W'(INTERVAL_SEC - 1));

        f_unav  = (st_reg.any_unav & ~clear_stats) | unav_now;
        f_oa    = (st_reg.any_oa & ~clear_stats) | oa_now;
        f_line  = (st_reg.any_line & ~clear_stats) | bipolar_violation | excess_zeros_event;
        f_los   = (st_reg.any_los & ~clear_stats) | loss_of_signal;
        pviol_c = clear_stats ? '0 : st_reg.pviol_sec;
        cviol_c = clear_stats ? '0 : st_reg.cviol_sec;
        // saturate at the severe threshold, nothing above it matters
        if (pviol_c != SEVERE_CV) begin
            pviol_c = pviol_c + SCNT_W'(pbit_violation);
        end
        if (cviol_c != SEVERE_CV) begin
            cviol_c = cviol_c + SCNT_W'(cbit_ev);
        end

        st_next.any_unav  = ~sec_tick & f_unav;
        st_next.any_oa    = ~sec_tick & f_oa;
        st_next.any_line  = ~sec_tick & f_line;
        st_next.any_los   = ~sec_tick & f_los;
        st_next.pviol_sec = sec_tick ? '0 : pviol_c;
        st_next.cviol_sec = sec_tick ? '0 : cviol_c;

        inc = '0;
        inc[P_UNAV] = INC_W'(sec_tick & f_unav);
        inc[P_SFRM] = INC_W'(sec_tick & f_oa);
        inc[P_LNCV] = INC_W'(bipolar_violation) + INC_W'(excess_zeros_event);
        inc[P_LNES] = INC_W'(sec_tick & (f_line | f_los));
        inc[P_PBES] = INC_W'(sec_tick & ~f_unav & ((pviol_c != '0) | f_oa));
        inc[P_PBSS] = INC_W'(sec_tick & ~f_unav & ((pviol_c >= SEVERE_CV) | f_oa));
        inc[P_PBCV] = INC_W'(pbit_violation);
        inc[P_CBCV] = INC_W'(cbit_ev);
        inc[P_CBES] = INC_W'(sec_tick & ~f_unav & ((cviol_c != '0) | f_oa));
        inc[P_CBSS] = INC_W'(sec_tick & ~f_unav & ((cviol_c >= SEVERE_CV) | f_oa));
        inc[P_FERR] = INC_W'(fbit_error);
        inc[P_MERR] = INC_W'(mbit_error);

        if (clear_stats || sec_tick) begin
            st_next.sec_timer = '0;
        end else begin
            st_next.sec_timer = st_reg.sec_timer + TIMER_W'(1);
        end
        if (clear_stats || iv_end) begin
            st_next.iv_sec = '0;
        end else if (sec_tick) begin
            st_next.iv_sec = st_reg.iv_sec + SEC_W'(1);
        end

        if (iv_end) begin
            for (int i = 0; i < NPAR; i++) begin
                st_next.total[i] = st_reg.total[i] + cur_next[i]
                                   - st_reg.hist[st_reg.wr_ptr][i];
            end
            st_next.hist[st_reg.wr_ptr]      = cur_next;
            st_next.hist_time[st_reg.wr_ptr] = st_reg.cur_start;
            st_next.cur_start                = time_of_day;
            if (st_reg.wr_ptr == IDX_W'(HIST_DEPTH - 1)) begin
                st_next.wr_ptr = '0;
            end else begin
                st_next.wr_ptr = st_reg.wr_ptr + IDX_W'(1);
            end
        end

        if (clear_stats) begin
            st_next.hist      = '0;
            st_next.hist_time = '0;
            st_next.total     = '0;
            st_next.wr_ptr    = '0;
            st_next.cur_start = time_of_day;
        end

        // entry 0 is the newest record; selections past the depth read zero
        rd_idx = {1'b0, st_reg.wr_ptr} + (IDX_W + 1)'(HIST_DEPTH - 1)
                 - {1'b0, hist_sel};
        if (rd_idx >= (IDX_W + 1)'(HIST_DEPTH)) begin
            rd_idx = rd_idx - (IDX_W + 1)'(HIST_DEPTH);
        end
        if (hist_sel >= IDX_W'(HIST_DEPTH)) begin
            st_next.rd_hist = '0;
            st_next.rd_time = '0;
        end else begin
            st_next.rd_hist = st_reg.hist[rd_idx[IDX_W-1:0]];
            st_next.rd_time = st_reg.hist_time[rd_idx[IDX_W-1:0]];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // current-interval counters
    // ------------------------------------------------------------
    for (genvar p = 0; p < NPAR; p++) begin : g_cnt
        dspm_counter #(.W(CW), .IW(INC_W)) u_cnt (
            .clock      (clock),
            .reset      (reset),
            .ctl        (stats_ctl),
            .inc        (inc[p]),
            .count      (current_counts[p]),
            .count_next (cur_next[p])
        );
    end

    // ------------------------------------------------------------
    // alarm counters
    // ------------------------------------------------------------
    for (genvar a = 0; a < NALM; a++) begin : g_alm
        dspm_alarm_count #(.W(ACW)) u_ds3 (
            .clock  (clock),
            .reset  (reset),
            .level  (ds3_alarm[a]),
            .enable (1'b1),
            .clear  (clear_alarms),
            .count  (ds3_alarm_counts[a])
        );
        for (genvar q = 0; q < NPORT; q++) begin : g_port
            dspm_alarm_count #(.W(ACW)) u_port (
                .clock  (clock),
                .reset  (reset),
                .level  (port_alarm[q][a]),
                .enable (card_present),
                .clear  (clear_alarms),
                .count  (port_alarm_counts[q][a])
            );
        end
    end

    assign current_start_time = st_reg.cur_start;
    assign total_counts       = st_reg.total;
    assign hist_counts        = st_reg.rd_hist;
    assign hist_start_time    = st_reg.rd_time;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_unav_tick;
        sec_tick && f_unav && !iv_end;
    endsequence
    sequence s_push;
        iv_end;
    endsequence

    a_unav_count: assert property (s_unav_tick |=>
        current_counts[P_UNAV] == $past(current_counts[P_UNAV]) + CW'(1))
        else $error("unavailable second not counted");
    a_errsec_inhibit: assert property (s_unav_tick |=>
        current_counts[P_PBES] == $past(current_counts[P_PBES])
        && current_counts[P_CBES] == $past(current_counts[P_CBES]))
        else $error("errored second counted while unavailable");
    a_framing_count: assert property (sec_tick && f_oa && !iv_end |=>
        current_counts[P_SFRM] == $past(current_counts[P_SFRM]) + CW'(1))
        else $error("severe framing second missed");
    a_severe_thresh: assert property (sec_tick && !f_unav && !f_oa && !iv_end
        && pviol_c < SEVERE_CV |=> current_counts[P_PBSS] == $past(current_counts[P_PBSS]))
        else $error("severe p-bit second below threshold");
    a_cbit_mode: assert property (!cbit_parity_mode && !clear_stats && !iv_end |=>
        current_counts[P_CBCV] == $past(current_counts[P_CBCV]))
        else $error("c-bit violation counted outside c-bit mode");
    a_hist_push: assert property (s_push |=> current_counts == '0
        && st_reg.hist[$past(st_reg.wr_ptr)] == $past(cur_next))
        else $error("interval record not pushed");
    a_start_time: assert property (s_push |=>
        current_start_time == $past(time_of_day)
        && st_reg.hist_time[$past(st_reg.wr_ptr)] == $past(current_start_time))
        else $error("interval start time lost");
    a_clear_all: assert property (clear_stats |=>
        total_counts == '0 && st_reg.wr_ptr == '0 && st_reg.iv_sec == '0)
        else $error("statistics clear incomplete");
endmodule // dspm_perf_monitor

// *** testbench/dspm_framer_model.sv ***
// dspm_framer_model: framer event source, a burst of pulses per request
// assumes go is one cycle wide and mask holds until the burst ends
`timescale 1ns/1ns

module dspm_framer_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // request
    input  wire logic [5:0] mask,
    input  wire logic [7:0] len,
    input  wire logic       go,
    // events: bipolar, zeros, pbit, cbit, fbit, mbit
    output logic      [5:0] ev
);
    logic [7:0] left_reg;

    always_ff @(posedge clock) begin
        if (reset) begin
            left_reg <= 8'h00;
        end else if (go) begin
            left_reg <= len;
        end else if (left_reg != 8'h00) begin
            left_reg <= left_reg - 8'h01;
        end
    end
    // events stay low outside a burst so a stray count shows up
    assign ev = (left_reg != 8'h00) ? mask : 6'h00;
endmodule // dspm_framer_model

// *** testbench/dspm_perf_monitor_tb.sv ***
// dspm_perf_monitor_tb: self-checking bench for the performance monitor
// assumes a short second so one whole interval fits in the run
`timescale 1ns/1ns

module dspm_perf_monitor_tb
    import dspm_pkg::*;
;
    localparam int SC = 60;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [5:0] mask = 6'h00;
    logic [7:0] len = 8'h00;
    logic go = 1'b0;
    logic [5:0] ev;
    logic [5:0] lv = 6'h00;
    logic mode = 1'b0;
    logic [2:0] alm = 3'h0;
    logic card = 1'b0;
    logic [11:0] palm = 12'h000;
    logic clear_stats = 1'b0;
    logic clear_alarms = 1'b0;
    logic [TOD_W-1:0] tod = 11'h000;
    logic [IDX_W-1:0] sel = 7'h00;
    dspm_rec_t cur, tot, hist;
    logic [TOD_W-1:0] cst, hst;
    logic [NALM-1:0][ACW-1:0] dac;
    logic [NPORT-1:0][NALM-1:0][ACW-1:0] pac;
    int n_fail = 0;
    int n_compared = 0;

    always #25 clock = ~clock;

    dspm_framer_model fm (.clock(clock), .reset(reset), .mask(mask), .len(len), .go(go),
        .ev(ev));

    dspm_perf_monitor #(.SEC_CYCLES(SC)) dut (.clock(clock), .reset(reset),
        .bipolar_violation(ev[0]), .excess_zeros_event(ev[1]), .pbit_violation(ev[2]),
        .cbit_parity_error(ev[3]), .fbit_error(ev[4]), .mbit_error(ev[5]),
        .out_of_frame_defect(lv[0]), .ais_detected(lv[1]), .loss_of_signal(lv[2]),
        .link_down(lv[3]), .link_in_test(lv[4]), .signaling_down(lv[5]),
        .cbit_parity_mode(mode), .ds3_alarm(alm), .card_present(card),
        .port_alarm(palm), .clear_stats(clear_stats), .clear_alarms(clear_alarms),
        .time_of_day(tod), .hist_sel(sel), .current_counts(cur),
        .current_start_time(cst), .total_counts(tot), .hist_counts(hist),
        .hist_start_time(hst), .ds3_alarm_counts(dac), .port_alarm_counts(pac));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic clr(input logic [TOD_W-1:0] t);
        @(posedge clock);
        clear_stats <= 1'b1;
        tod <= t;
        @(posedge clock);
        clear_stats <= 1'b0;
    endtask
    task automatic burst(input logic [5:0] m, input logic [7:0] n);
        @(posedge clock);
        mask <= m;
        len <= n;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        look(int'(n) + 2);
    endtask
    task automatic stop_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic t_events;
        clr(11'h000);
        burst(6'h03, 8'h05);
        chk(cur[P_LNCV], 32'h0000000A);
        burst(6'h04, 8'h07);
        chk(cur[P_PBCV], 32'h7);
        burst(6'h08, 8'h03);
        chk(cur[P_CBCV], 32'h0);
        @(posedge clock);
        mode <= 1'b1;
        burst(6'h08, 8'h03);
        chk(cur[P_CBCV], 32'h3);
        burst(6'h30, 8'h04);
        chk(cur[P_FERR], 32'h4);
        chk(cur[P_MERR], 32'h4);
        $display("test events done");
    endtask
    task automatic t_seconds;
        for (int i = 0; i < 4; i++) begin
            clr(11'h000);
            lv <= 6'(6'h07 | (6'h08 << i));
            repeat (10) @(posedge clock);
            lv <= 6'h00;
            look(SC * 2 + 10);
            chk(cur[P_UNAV], 32'(i < 3));
            chk(cur[P_SFRM], 32'h1);
            chk(cur[P_LNES], 32'h1);
            chk(cur[P_PBES], 32'(i == 3));
            chk(cur[P_CBSS], 32'(i == 3));
        end
        $display("test seconds done");
    endtask
    task automatic t_severe;
        clr(11'h000);
        burst(6'h0C, 8'h2B);
        burst(6'h04, 8'h01);
        look(SC * 2);
        chk(cur[P_PBCV], 32'h2C);
        chk(cur[P_PBSS], 32'h1);
        chk(cur[P_CBSS], 32'h0);
        chk(cur[P_CBES], 32'h1);
        $display("test severe done");
    endtask
    task automatic t_alarm;
        @(posedge clock);
        alm <= 3'h7;
        repeat (5) @(posedge clock);
        alm <= 3'h0;
        repeat (2) @(posedge clock);
        alm <= 3'h2;
        palm <= 12'hFFF;
        repeat (2) @(posedge clock);
        alm <= 3'h0;
        palm <= 12'h000;
        card <= 1'b1;
        repeat (2) @(posedge clock);
        palm <= 12'h008;
        look(3);
        chk({16'h0, dac[AL_YEL]}, 32'h1);
        chk({16'h0, dac[AL_BLU]}, 32'h2);
        chk({16'h0, pac[1][AL_YEL]}, 32'h1);
        chk({16'h0, pac[0][AL_YEL]}, 32'h0);
        @(posedge clock);
        clear_alarms <= 1'b1;
        @(posedge clock);
        clear_alarms <= 1'b0;
        look(2);
        chk({16'h0, dac[AL_BLU]}, 32'h0);
        $display("test alarm done");
    endtask
    task automatic t_interval;
        clr(11'h123);
        tod <= 11'h132;
        burst(6'h10, 8'h03);
        look(SC * 900);
        chk(cur[P_FERR], 32'h0);
        chk(tot[P_FERR], 32'h3);
        chk(32'(cst), 32'h132);
        chk(hist[P_FERR], 32'h3);
        chk(32'(hst), 32'h123);
        @(posedge clock);
        sel <= 7'h01;
        look(2);
        chk(hist[P_FERR], 32'h0);
        @(posedge clock);
        sel <= 7'h60;
        look(2);
        chk(hist[P_FERR], 32'h0);
        @(posedge clock);
        sel <= 7'h00;
        clr(11'h000);
        look(2);
        chk(tot[P_FERR], 32'h0);
        chk(hist[P_FERR], 32'h0);
        $display("test interval done");
    endtask

    initial begin
        #(70000 * 50);
        n_fail++;
        stop_test();
    end

    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        t_events();
        t_seconds();
        t_severe();
        t_alarm();
        t_interval();
        stop_test();
    end
endmodule // dspm_perf_monitor_tb
